// >>> rtl/dma_addressing.sv
// Summary of operation
// - 8-bit direct: even address, byte with accumulator
// - even nibble low, odd nibble high
// - 8-bit direct banks like 4-bit direct
// - flag clear: low half bank 0, high bank 15
// - flag set: bank select register is bank
// - 8-bit direct: transfer, exchange, port in/out
// - primary pointer bank is flag AND select
// - secondary and mixed pointers always bank 0
// - auto step changes only pointer low nibble
// - secondary/mixed pointers: transfer and exchange only
// - primary pointer: transfer, alu, compare, ports
// - 8-bit indirect clears pointer bit 0, pairs
// - 8-bit indirect bank is flag AND select
// - 8-bit indirect: transfer, exchange, skip-if-equal
// - exchange captures and loads in one access
// - 1-bit direct: set, reset, test only
// - bit modes: logic ops, transfer, test-clear
// - three bit manipulation address variants
`timescale 1ns/1ps
`default_nettype none

module dma_addressing #(
   parameter int REG_ADDR_W = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // register port
   input wire logic [REG_ADDR_W-1:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [7:0] bus_rdata,
   // operation request from the core
   input wire logic op_valid,
   input wire dma_pkg::dma_req_type op_req,
   output logic op_ready,
   output logic op_done,
   output logic op_illegal,
   output logic op_skip,
   output logic [7:0] acc_rdata,
   output logic [1:0] bit_index,
   // data memory port
   output dma_pkg::dma_mem_type mem,
   input wire logic [3:0] mem_rdata
);
   import dma_pkg::*;

   // the register decode reads the low four index bits, so narrower ports cannot work
   if (REG_ADDR_W < 4) begin : g_chk
      $error("dma_addressing: REG_ADDR_W must be at least 4");
   end

   dma_state_type r_reg;
   dma_state_type r_next;

   ////////////////////////////////////////////////////////////////////////////////
   // decode helpers
   function automatic logic is_read(input dma_op_type op);
      is_read = !(op == DMA_O_STORE || op == DMA_O_OUT);
   endfunction : is_read

   function automatic logic is_write(input dma_op_type op);
      is_write = (op == DMA_O_STORE || op == DMA_O_OUT || op == DMA_O_XCH);
   endfunction : is_write

   function automatic logic is_wide(input dma_mode_type m);
      is_wide = (m == DMA_M_DIR8 || m == DMA_M_HL8);
   endfunction : is_wide

   function automatic logic is_bitop(input dma_op_type op);
      is_bitop = (op >= DMA_O_BSET);
   endfunction : is_bitop

   // which operations each addressing mode may serve
   function automatic logic legal(input dma_mode_type m, input dma_op_type op);
      logic xfer;
      xfer = (op == DMA_O_LOAD || op == DMA_O_STORE || op == DMA_O_XCH);
      case (m)
         DMA_M_DIR4, DMA_M_DIR8: begin
            legal = xfer || op == DMA_O_IN || op == DMA_O_OUT;
         end
         DMA_M_HL, DMA_M_HL_INC, DMA_M_HL_DEC: begin
            legal = !is_bitop(op);
         end
         DMA_M_DE, DMA_M_DL: begin
            legal = xfer;
         end
         DMA_M_HL8: begin
            legal = xfer || op == DMA_O_SKE;
         end
         DMA_M_BIT_DIR: begin
            legal = (op == DMA_O_BSET || op == DMA_O_BCLR || op == DMA_O_BTEST);
         end
         DMA_M_BIT_FMEM, DMA_M_BIT_PMEM, DMA_M_BIT_HMEM: begin
            legal = is_bitop(op);
         end
         default: begin
            legal = 1'b0;
         end
      endcase
   endfunction : legal

   // bank chosen by the flag, the select register and the offset
   function automatic logic [3:0] direct_bank(input logic en, input logic [3:0] sel,
                                              input logic [7:0] off);
      if (en) begin
         direct_bank = sel;
      end else begin
         direct_bank = off[7] ? DMA_BANK_PERIPH : DMA_BANK_RAM0;
      end
   endfunction : direct_bank

   // full 12-bit address of the first (or only) nibble
   function automatic logic [11:0] first_addr(input dma_req_type q, input dma_state_type s);
      logic [3:0] ptr_bank;
      ptr_bank = s.bank_en ? s.bank_sel : DMA_BANK_RAM0;
      case (q.mode)
         DMA_M_DIR4, DMA_M_BIT_DIR: begin
            first_addr = {direct_bank(s.bank_en, s.bank_sel, q.operand), q.operand};
         end
         DMA_M_DIR8: begin
            // same bank path as the nibble form, offset forced even
            first_addr = {direct_bank(s.bank_en, s.bank_sel, q.operand),
                          q.operand[7:1], 1'b0};
         end
         DMA_M_HL, DMA_M_HL_INC, DMA_M_HL_DEC: begin
            first_addr = {ptr_bank, s.ph, s.pl};
         end
         DMA_M_DE: begin
            first_addr = {DMA_BANK_RAM0, s.sh, s.sl};
         end
         DMA_M_DL: begin
            first_addr = {DMA_BANK_RAM0, s.sh, s.pl};
         end
         DMA_M_HL8: begin
            first_addr = {ptr_bank, s.ph, s.pl[3:1], 1'b0};
         end
         DMA_M_BIT_FMEM: begin
            // reachable regardless of bank setting: i/o ports or interrupt area
            first_addr = {(q.operand[4] ? DMA_FMEM_IO : DMA_FMEM_IRQ), q.operand[3:0]};
         end
         DMA_M_BIT_PMEM: begin
            first_addr = {DMA_PMEM_TOP, q.operand[3:0], s.pl[3:2]};
         end
         DMA_M_BIT_HMEM: begin
            first_addr = {ptr_bank, s.ph, q.operand[3:0]};
         end
         default: begin
            first_addr = 12'h000;
         end
      endcase
   endfunction : first_addr

   ////////////////////////////////////////////////////////////////////////////////
   // next-state logic
   always_comb begin
      dma_req_type q;
      logic [11:0] a;
      logic [3:0] nib;
      q = op_req;
      a = 12'h000;
      nib = 4'h0;
      r_next = r_reg;
      r_next.done = 1'b0;
      r_next.illegal = 1'b0;
      r_next.mem.rd = 1'b0;
      r_next.mem.wr = 1'b0;
      case (r_reg.fsm)
         DMA_S_IDLE: begin
            if (op_valid) begin
               if (!legal(q.mode, q.op)) begin
                  r_next.illegal = 1'b1;
                  r_next.last_illegal = 1'b1;
               end else begin
                  a = first_addr(q, r_reg);
                  if (q.mode == DMA_M_BIT_PMEM) begin
                     q.bitn = r_reg.pl[1:0]; // bit from the pointer low bits
                  end
                  r_next.req = q;
                  r_next.mem.addr = a;
                  r_next.mem.rd = is_read(q.op);
                  // exchange reads old and writes new in the same access
                  r_next.mem.wr = is_write(q.op);
                  r_next.mem.wdata = q.wdata[3:0];
                  r_next.skip = 1'b0;
                  r_next.last_bank = a[11:8];
                  r_next.last_illegal = 1'b0;
                  r_next.fsm = DMA_S_LO;
               end
            end
         end
         DMA_S_LO: begin
            if (is_wide(r_reg.req.mode)) begin
               r_next.mem.addr = {r_reg.mem.addr[11:1], 1'b1};
               r_next.mem.rd = is_read(r_reg.req.op);
               r_next.mem.wr = is_write(r_reg.req.op);
               r_next.mem.wdata = r_reg.req.wdata[7:4];
               r_next.fsm = DMA_S_HI;
            end else begin
               r_next.fsm = DMA_S_FIN;
            end
         end
         DMA_S_HI: begin
            if (is_read(r_reg.req.op)) begin
               r_next.acc[3:0] = mem_rdata;
            end
            r_next.fsm = DMA_S_FIN;
         end
         DMA_S_FIN: begin
            r_next.done = 1'b1;
            r_next.fsm = DMA_S_IDLE;
            if (is_read(r_reg.req.op)) begin
               if (is_wide(r_reg.req.mode)) begin
                  r_next.acc[7:4] = mem_rdata;
               end else begin
                  r_next.acc = {4'h0, mem_rdata};
               end
            end
            if (r_reg.req.op == DMA_O_SKE) begin
               r_next.skip = is_wide(r_reg.req.mode) ?
                  ({mem_rdata, r_reg.acc[3:0]} == r_reg.req.wdata) :
                  (mem_rdata == r_reg.req.wdata[3:0]);
            end
            // set and reset write the nibble back, test-clear only when the tested bit was set
            nib = mem_rdata;
            nib[r_reg.req.bitn] = (r_reg.req.op == DMA_O_BSET);
            if (r_reg.req.op == DMA_O_BTCLR) begin
               r_next.skip = mem_rdata[r_reg.req.bitn];
            end
            if (r_reg.req.op == DMA_O_BSET || r_reg.req.op == DMA_O_BCLR ||
                (r_reg.req.op == DMA_O_BTCLR && mem_rdata[r_reg.req.bitn])) begin
               r_next.mem.wr = 1'b1;
               r_next.mem.wdata = nib;
               r_next.fsm = DMA_S_CLR;
            end
            // only the low pointer nibble steps, wrapping inside it
            if (r_reg.req.mode == DMA_M_HL_INC) begin
               r_next.pl = 4'(r_reg.pl + 4'h1);
            end else if (r_reg.req.mode == DMA_M_HL_DEC) begin
               r_next.pl = 4'(r_reg.pl - 4'h1);
            end
         end
         DMA_S_CLR: begin
            r_next.fsm = DMA_S_IDLE;
         end
         default: begin
            r_next.fsm = DMA_S_IDLE;
         end
      endcase

      // register writes come last so software wins over a pointer step
      if (bus_wr) begin
         case (bus_addr[3:0])
            DMA_REG_BANK: begin
               r_next.bank_en = bus_wdata[DMA_BANK_EN_POS];
               r_next.bank_sel = bus_wdata[3:0];
            end
            DMA_REG_PRIMARY: begin
               r_next.ph = bus_wdata[7:4];
               r_next.pl = bus_wdata[3:0];
            end
            DMA_REG_SECONDARY: begin
               r_next.sh = bus_wdata[7:4];
               r_next.sl = bus_wdata[3:0];
            end
            default: begin
            end
         endcase
      end
      // read data stands only in the cycle after the strobe
      r_next.bus_rdata = 8'h00;
      if (bus_rd) begin
         case (bus_addr[3:0])
            DMA_REG_BANK: r_next.bus_rdata = {3'b000, r_reg.bank_en, r_reg.bank_sel};
            DMA_REG_PRIMARY: r_next.bus_rdata = {r_reg.ph, r_reg.pl};
            DMA_REG_SECONDARY: r_next.bus_rdata = {r_reg.sh, r_reg.sl};
            DMA_REG_STATUS: r_next.bus_rdata = {r_reg.last_bank, 3'b000, r_reg.last_illegal};
            default: r_next.bus_rdata = 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         r_reg <= '0;
         r_reg.fsm <= DMA_S_IDLE;
         r_reg.bank_en <= DMA_BANK_EN_RST;
         r_reg.bank_sel <= DMA_BANK_SEL_RST;
         r_reg.ph <= DMA_PTR_RST;
         r_reg.pl <= DMA_PTR_RST;
         r_reg.sh <= DMA_PTR_RST;
         r_reg.sl <= DMA_PTR_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs
   assign op_ready = (r_reg.fsm == DMA_S_IDLE);
   assign op_done = r_reg.done;
   assign op_illegal = r_reg.illegal;
   assign op_skip = r_reg.skip;
   assign acc_rdata = r_reg.acc;
   assign bit_index = r_reg.req.bitn;
   assign mem = r_reg.mem;
   assign bus_rdata = r_reg.bus_rdata;

endmodule : dma_addressing

`default_nettype wire

// >>> rtl/dma_pkg.sv
package dma_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // register map of the plain register port
   localparam logic [3:0] DMA_REG_BANK = 4'h0; // bank_enable_flag, bank_select_register
   localparam logic [3:0] DMA_REG_PRIMARY = 4'h1; // primary pointer pair, high | low
   localparam logic [3:0] DMA_REG_SECONDARY = 4'h2; // secondary pointer pair, high | low
   localparam logic [3:0] DMA_REG_STATUS = 4'h3; // last active bank, last refusal
   localparam int DMA_BANK_EN_POS = 4;
   localparam int DMA_STAT_ILL_POS = 0;
   localparam int DMA_STAT_BANK_POS = 4;
   localparam logic DMA_BANK_EN_RST = 1'b0;
   localparam logic [3:0] DMA_BANK_SEL_RST = 4'h0;
   localparam logic [3:0] DMA_PTR_RST = 4'h0;

   ////////////////////////////////////////////////////////////////////////////////
   // fixed banks and bit-area prefixes
   localparam logic [3:0] DMA_BANK_RAM0 = 4'h0;
   localparam logic [3:0] DMA_BANK_PERIPH = 4'hf;
   localparam logic [7:0] DMA_FMEM_IO = 8'hff; // ff0h..fffh
   localparam logic [7:0] DMA_FMEM_IRQ = 8'hfb; // fb0h..fbfh
   localparam logic [5:0] DMA_PMEM_TOP = 6'h3f; // fc0h..fffh

   ////////////////////////////////////////////////////////////////////////////////
   // addressing modes and operations
   typedef enum logic [3:0] {
      DMA_M_DIR4 = 4'h0, DMA_M_DIR8 = 4'h1, DMA_M_HL = 4'h2, DMA_M_HL_INC = 4'h3,
      DMA_M_HL_DEC = 4'h4, DMA_M_DE = 4'h5, DMA_M_DL = 4'h6, DMA_M_HL8 = 4'h7,
      DMA_M_BIT_DIR = 4'h8, DMA_M_BIT_FMEM = 4'h9, DMA_M_BIT_PMEM = 4'ha,
      DMA_M_BIT_HMEM = 4'hb
   } dma_mode_type;

   typedef enum logic [3:0] {
      DMA_O_LOAD = 4'h0, DMA_O_STORE = 4'h1, DMA_O_XCH = 4'h2, DMA_O_SKE = 4'h3,
      DMA_O_IN = 4'h4, DMA_O_OUT = 4'h5, DMA_O_ALU = 4'h6, DMA_O_BSET = 4'h7,
      DMA_O_BCLR = 4'h8, DMA_O_BTEST = 4'h9, DMA_O_BAND = 4'ha, DMA_O_BOR = 4'hb,
      DMA_O_BXOR = 4'hc, DMA_O_BMOV = 4'hd, DMA_O_BTCLR = 4'he
   } dma_op_type;

   typedef enum logic [4:0] {
      DMA_S_IDLE = 5'b00001, DMA_S_LO = 5'b00010, DMA_S_HI = 5'b00100,
      DMA_S_FIN = 5'b01000, DMA_S_CLR = 5'b10000
   } dma_fsm_type;

   ////////////////////////////////////////////////////////////////////////////////
   // carriers
   typedef struct packed {
      dma_mode_type mode;
      dma_op_type op;
      logic [7:0] operand;
      logic [7:0] wdata;
      logic [1:0] bitn;
   } dma_req_type;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [11:0] addr;
      logic [3:0] wdata;
   } dma_mem_type;

   typedef struct packed {
      dma_fsm_type fsm;
      dma_req_type req;
      dma_mem_type mem;
      logic [7:0] acc;
      logic done;
      logic illegal;
      logic skip;
      logic bank_en;
      logic [3:0] bank_sel;
      logic [3:0] ph;
      logic [3:0] pl;
      logic [3:0] sh;
      logic [3:0] sl;
      logic [7:0] bus_rdata;
      logic [3:0] last_bank;
      logic last_illegal;
   } dma_state_type;

endpackage : dma_pkg

// >>> verification/dma_addressing_sva.sv
`timescale 1ns/1ps
`default_nettype none

module dma_addressing_sva #(
   parameter int REG_ADDR_W = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // register port
   input wire logic [REG_ADDR_W-1:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_wr,
   // operation port
   input wire logic op_valid,
   input wire dma_pkg::dma_req_type op_req,
   input wire logic op_ready,
   input wire logic op_illegal,
   // data memory port
   input wire dma_pkg::dma_mem_type mem
);
   import dma_pkg::*;
   logic ben_reg;
   logic [3:0] bsel_reg;
   logic take;
   logic xfer;

   ////////////////////////////////////////////////////////////////////////////////
   // shadow of the bank register, so bank checks need no peek inside
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ben_reg <= 1'b0;
         bsel_reg <= 4'h0;
      end else if (bus_wr && bus_addr[3:0] == DMA_REG_BANK) begin
         ben_reg <= bus_wdata[DMA_BANK_EN_POS];
         bsel_reg <= bus_wdata[3:0];
      end
   end
   // accepted request and its operation class
   assign take = op_valid && op_ready;
   assign xfer = op_req.op inside {DMA_O_LOAD, DMA_O_STORE, DMA_O_XCH};

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   ////////////////////////////////////////////////////////////////////////////////
   dir8_refuse_a: assert property (take && op_req.mode == DMA_M_DIR8 &&
      !(xfer || op_req.op inside {DMA_O_IN, DMA_O_OUT}) |=> op_illegal && !mem.rd && !mem.wr)
      else $error("byte direct op not refused");
   ptr2_refuse_a: assert property (take && op_req.mode inside {DMA_M_DE, DMA_M_DL} &&
      !xfer |=> op_illegal) else $error("second pointer op not refused");
   hl8_refuse_a: assert property (take && op_req.mode == DMA_M_HL8 &&
      !(xfer || op_req.op == DMA_O_SKE) |=> op_illegal) else $error("byte indirect not refused");
   bitdir_refuse_a: assert property (take && op_req.mode == DMA_M_BIT_DIR &&
      !(op_req.op inside {DMA_O_BSET, DMA_O_BCLR, DMA_O_BTEST}) |=> op_illegal)
      else $error("bit direct op not refused");
   ptr2_bank_a: assert property (take && op_req.mode inside {DMA_M_DE, DMA_M_DL} && xfer
      |=> (mem.rd || mem.wr) && mem.addr[11:8] == DMA_BANK_RAM0) else $error("second bank");
   hl_bank_a: assert property (take && ((op_req.mode inside {DMA_M_HL, DMA_M_HL_INC,
      DMA_M_HL_DEC} && op_req.op <= DMA_O_ALU) || (op_req.mode == DMA_M_HL8 &&
      (xfer || op_req.op == DMA_O_SKE))) |=> (mem.rd || mem.wr) &&
      mem.addr[11:8] == (ben_reg ? bsel_reg : DMA_BANK_RAM0)) else $error("pointer bank");
   dir_bank_a: assert property (take && op_req.mode inside {DMA_M_DIR4, DMA_M_DIR8} &&
      (xfer || op_req.op inside {DMA_O_IN, DMA_O_OUT}) |=> (mem.rd || mem.wr) &&
      mem.addr[7:1] == $past(op_req.operand[7:1]) && mem.addr[11:8] == (ben_reg ? bsel_reg :
      ($past(op_req.operand[7]) ? DMA_BANK_PERIPH : DMA_BANK_RAM0))) else $error("dir bank");
   byte_pair_a: assert property (take && op_req.mode inside {DMA_M_DIR8, DMA_M_HL8} &&
      op_req.op == DMA_O_LOAD |=> mem.rd && !mem.addr[0] ##1 mem.rd &&
      mem.addr == $past(mem.addr) + 12'h001) else $error("byte halves not paired");
   fmem_addr_a: assert property (take && op_req.mode == DMA_M_BIT_FMEM &&
      op_req.op >= DMA_O_BSET |=> mem.rd && mem.addr == {($past(op_req.operand[4]) ?
      DMA_FMEM_IO : DMA_FMEM_IRQ), $past(op_req.operand[3:0])}) else $error("fixed bit area");
endmodule : dma_addressing_sva

bind dma_addressing dma_addressing_sva #(.REG_ADDR_W(REG_ADDR_W)) sva_i (.clk, .nrst,
   .bus_addr, .bus_wdata, .bus_wr, .op_valid, .op_req, .op_ready, .op_illegal, .mem);

`default_nettype wire

// >>> verification/dma_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module dma_mem_model (
   // clock
   input wire logic clk,
   // data memory port
   input wire dma_pkg::dma_mem_type mem,
   output logic [3:0] mem_rdata
);
   import dma_pkg::*;
   logic [3:0] cells [4096];

   // answer one cycle after a read; otherwise the line wanders, stale data never matches
   always @(posedge clk) begin
      if (mem.rd) begin
         mem_rdata <= cells[mem.addr];
      end else begin
         mem_rdata <= ~mem_rdata;
      end
      if (mem.wr) begin
         cells[mem.addr] <= mem.wdata;
      end
   end
   initial mem_rdata = 4'h0;
endmodule : dma_mem_model

`default_nettype wire

// >>> verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import dma_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [3:0] bus_addr = 4'h0;
   logic [7:0] bus_wdata = 8'h00;
   logic bus_wr = 1'b0;
   logic bus_rd = 1'b0;
   logic [7:0] bus_rdata, acc_rdata, x, w;
   logic op_valid = 1'b0;
   dma_req_type op_req = '0;
   logic op_ready, op_done, op_illegal, op_skip, ill, skp, ben, rdy;
   dma_mem_type mem;
   logic [3:0] mem_rdata, bsel, ph, pl, sh, sl, db, hb;
   logic [3:0] ref_mem [4096];
   logic [11:0] acc, rdv, a;
   logic [31:0] seed = 32'h0000_0004;
   logic [1:0] b, bidx;
   int n_fail = 0;
   int comparisons = 0;
   int i, k;
   dma_mode_type im [7] = '{DMA_M_DIR8, DMA_M_DIR8, DMA_M_DE, DMA_M_DL, DMA_M_HL8, DMA_M_HL8,
      DMA_M_BIT_DIR};
   dma_op_type io [7] = '{DMA_O_ALU, DMA_O_SKE, DMA_O_ALU, DMA_O_SKE, DMA_O_ALU, DMA_O_IN,
      DMA_O_BAND};

   always #5 clk = ~clk;

   dma_addressing #(.REG_ADDR_W(4)) uut (.clk(clk), .nrst(nrst), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
      .op_valid(op_valid), .op_req(op_req), .op_ready(op_ready), .op_done(op_done),
      .op_illegal(op_illegal), .op_skip(op_skip), .acc_rdata(acc_rdata), .bit_index(bidx),
      .mem(mem), .mem_rdata(mem_rdata));
   dma_mem_model mdl (.clk(clk), .mem(mem), .mem_rdata(mem_rdata));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   task automatic chk(input string s, input logic [11:0] e, input logic [11:0] g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", s, e, g);
      end
   endtask : chk

   task automatic report_and_stop();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : report_and_stop

   // register port cycles: strobes one cycle, read data in the cycle after
   task automatic wr(input logic [3:0] ad, input logic [7:0] d);
      @(posedge clk);
      bus_wr <= 1'b1;
      bus_addr <= ad;
      bus_wdata <= d;
      @(posedge clk);
      bus_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] ad);
      @(posedge clk);
      bus_rd <= 1'b1;
      bus_addr <= ad;
      @(posedge clk);
      bus_rd <= 1'b0;
      #1 rdv = {4'h0, bus_rdata};
   endtask : rd

   // one request, held for one cycle, then a bounded wait for done or refusal
   task automatic op(input dma_mode_type m, input dma_op_type o, input logic [7:0] xo, wd,
      input logic [1:0] bn);
      @(posedge clk);
      op_valid <= 1'b1;
      op_req <= '{m, o, xo, wd, bn};
      @(posedge clk);
      op_valid <= 1'b0;
      for (int n = 0; n < 20; n++) begin
         #1;
         if (op_done === 1'b1 || op_illegal === 1'b1) break;
         @(posedge clk);
      end
      // a request that neither ends nor is refused within the wait counts as a mismatch
      chk("answer", 12'h001, {11'h000, op_done | op_illegal});
      ill = op_illegal;
      rdy = op_ready;
      skp = op_skip;
      acc = {4'h0, acc_rdata};
      @(posedge clk);
   endtask : op

   task automatic ld(input dma_mode_type m, input logic [7:0] xo, input logic [11:0] ad,
      input logic byt);
      op(m, DMA_O_LOAD, xo, 8'h00, 2'h0);
      chk("load", byt ? {4'h0, ref_mem[ad+1], ref_mem[ad]} : {8'h00, ref_mem[ad]}, acc);
   endtask : ld

   // bit op, then the touched nibble compared in memory
   task automatic bop(input dma_mode_type m, input dma_op_type o, input logic [1:0] bn,
      input logic [11:0] ad, input logic [1:0] n);
      logic v;
      v = ref_mem[ad][n];
      op(m, o, x, 8'h00, bn);
      // let the write-back of the closing edge land before peeking at the cell
      #1;
      if (o inside {DMA_O_BSET, DMA_O_BCLR, DMA_O_BTCLR}) ref_mem[ad][n] = (o == DMA_O_BSET);
      chk("bit index", {10'h000, n}, {10'h000, bidx});
      chk("bit mem", {8'h00, ref_mem[ad]}, {8'h00, mdl.cells[ad]});
      if (o == DMA_O_BTCLR) chk("tclr skip", {11'h000, v}, {11'h000, skp});
   endtask : bop

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      for (i = 0; i < 4096; i++) begin
         ref_mem[i] = 4'(rnd());
         mdl.cells[i] = ref_mem[i];
      end
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      // read-only and unmapped places ignore writes
      wr(DMA_REG_STATUS, 8'hff);
      wr(4'h9, 8'hff);
      for (i = 0; i < 5; i++) begin
         rd(i == 4 ? 4'h9 : 4'(i));
         chk("reg reset", 12'h000, rdv);
      end
      for (k = 0; k < 16; k++) begin
         x = 8'(rnd());
         w = 8'(rnd());
         b = 2'(rnd());
         ben = k[0];
         {bsel, ph, pl, sh, sl} = 20'(rnd());
         wr(DMA_REG_BANK, {3'h0, ben, bsel});
         wr(DMA_REG_PRIMARY, {ph, pl});
         wr(DMA_REG_SECONDARY, {sh, sl});
         db = ben ? bsel : (x[7] ? 4'hf : 4'h0);
         hb = ben ? bsel : 4'h0;
         a = {db, x[7:1], 1'b0};
         ld(DMA_M_DIR4, x, {db, x}, 1'b0);
         rd(DMA_REG_STATUS);
         chk("status bank", {8'h00, db}, {8'h00, rdv[7:4]});
         ld(DMA_M_DIR8, x & 8'hfe, a, 1'b1);
         op(DMA_M_DIR8, DMA_O_XCH, x & 8'hfe, w, 2'h0);
         chk("xch old", {4'h0, ref_mem[a+1], ref_mem[a]}, acc);
         {ref_mem[a+1], ref_mem[a]} = w;
         ld(DMA_M_DIR8, x & 8'hfe, a, 1'b1);
         ld(DMA_M_HL, 8'h00, {hb, ph, pl}, 1'b0);
         op(DMA_M_DE, DMA_O_STORE, 8'h00, w, 2'h0);
         ref_mem[{4'h0, sh, sl}] = w[3:0];
         ld(DMA_M_DE, 8'h00, {4'h0, sh, sl}, 1'b0);
         ld(DMA_M_DL, 8'h00, {4'h0, sh, pl}, 1'b0);
         a = {hb, ph, pl[3:1], 1'b0};
         ld(DMA_M_HL8, 8'h00, a, 1'b1);
         // equal compare on even passes, one bit off on odd
         op(DMA_M_HL8, DMA_O_SKE, 8'h00, {ref_mem[a+1], ref_mem[a]} ^ 8'(k[0]), 2'h0);
         chk("ske skip", {11'h000, ~k[0]}, {11'h000, skp});
         ld(k[0] ? DMA_M_HL_INC : DMA_M_HL_DEC, 8'h00, {hb, ph, pl}, 1'b0);
         pl = k[0] ? pl + 4'h1 : pl - 4'h1;
         rd(DMA_REG_PRIMARY);
         chk("ptr step", {4'h0, ph, pl}, rdv);
         bop(DMA_M_BIT_DIR, k[0] ? DMA_O_BSET : (k[1] ? DMA_O_BCLR : DMA_O_BTEST), b,
            {db, x}, b);
         bop(DMA_M_BIT_FMEM, DMA_O_BTCLR, b, {x[4] ? 8'hff : 8'hfb, x[3:0]}, b);
         bop(DMA_M_BIT_PMEM, DMA_O_BSET, b, {6'h3f, x[3:0], pl[3:2]}, pl[1:0]);
         bop(DMA_M_BIT_HMEM, k[1] ? DMA_O_BCLR : DMA_O_BXOR, b, {hb, ph, x[3:0]}, b);
      end
      for (i = 0; i < 7; i++) begin
         op(im[i], io[i], 8'h00, 8'h00, 2'h0);
         chk("refused", 12'h001, {11'h000, ill});
         chk("ready", 12'h001, {11'h000, rdy});
      end
      rd(DMA_REG_STATUS);
      chk("status refusal", 12'h001, {11'h000, rdv[DMA_STAT_ILL_POS]});
      report_and_stop();
   end

   // watchdog, well beyond the roughly 1500 cycles the run needs
   initial begin
      #60000;
      n_fail++;
      $display("MISMATCH watchdog expected finish seen hang");
      report_and_stop();
   end
endmodule : testbench

`default_nettype wire
